//--- logic/lpr_consts.svh
// Constants for the low-power DDR bank and power-state link
// Functional notes
// (RULE1) A10 high on write selects auto precharge
// (RULE2) Auto precharge starts after write recovery
// (RULE3) No command to bank during auto precharge
// (RULE4) Auto refresh: REF command with CKE high
// (RULE5) All banks idle tRP before auto refresh
// (RULE6) Refresh uses internal row counter, banks end idle
// (RULE7) Wait tRFC after auto refresh
// (RULE8) Self refresh entry: REF command, CKE low
// (RULE9) Hold CKE low throughout self refresh
// (RULE10) Keep driving CKE during self refresh
// (RULE11) Stable clock and NOP before self refresh exit
// (RULE12) Self refresh from idle, at least tRFC
// (RULE13) CKE low enters power down, gating inputs
// (RULE14) Idle before power down, tPDEX after exit
// (RULE15) Power down no longer than refresh period
// (RULE16) Power down lasts at least tCKE
// (RULE17) Clock stop only with CKE high, commands done
// (RULE18) Clock stop holds true low, complement high
// (RULE19) NOP after clock restart before access
// (RULE20) 200 us stable clock with NOP at power up
// (RULE21) Init: precharge all, two refreshes, mode, extended mode
// (RULE22) Mode registers programmed at init, banks idle
`ifndef LPR_CONSTS_SVH
`define LPR_CONSTS_SVH
`define LPR_CLK_NS 40
`define LPR_TINIT_NS 200000
`define LPR_TINIT_CYC ((`LPR_TINIT_NS + 2 * `LPR_CLK_NS - 1) / (2 * `LPR_CLK_NS))
`define LPR_TRP_CYC 3
`define LPR_TRFC_CYC 12
`define LPR_TWR_CYC 2
`define LPR_TRCD_CYC 3
`define LPR_TMRD_CYC 2
`define LPR_TCKE_CYC 2
`define LPR_TPDEX_CYC 2
`define LPR_PD_MAX_CYC 1000
`define LPR_BURST 4
`define LPR_ADDR_W 13
`define LPR_BANKS 4
`define LPR_AUTO_PRECHARGE_FLAG 10
`define LPR_RESTART_NOP_CYC 1
`define LPR_BA_MODE 2'h0
`define LPR_BA_EXT 2'h2
`define LPR_INIT_REFS 2'h2
`define LPR_MODE_VAL 13'h0032
`define LPR_EXT_VAL 13'h0000
`endif

//--- logic/lpr_pkg.sv
// Types shared by both ends of the link
package lpr_pkg;
	// {csN, rasN, casN, weN}
	typedef enum logic [3:0] {
		CMD_MRS  = 4'h0,
		CMD_REF  = 4'h1,
		CMD_PRE  = 4'h2,
		CMD_ACT  = 4'h3,
		CMD_WR   = 4'h4,
		CMD_RD   = 4'h5,
		CMD_BST  = 4'h6,
		CMD_NOP  = 4'h7,
		CMD_DSEL = 4'h8
	} lpr_cmd_t;
	typedef enum logic [1:0] {
		OP_ACT   = 2'h0,
		OP_WRITE = 2'h1,
		OP_PRE   = 2'h2,
		OP_REF   = 2'h3
	} lpr_op_t;
	typedef enum logic [3:0] {
		CS_INIT = 4'h0,
		CS_PALL = 4'h1,
		CS_REFI = 4'h3,
		CS_MRS  = 4'h2,
		CS_EMRS = 4'h6,
		CS_IDLE = 4'h7,
		CS_PDN  = 4'h5,
		CS_SREF = 4'h4,
		CS_STOP = 4'hF
	} lpr_cstate_t;
	typedef enum logic [1:0] {
		DS_NORM = 2'h0,
		DS_PDN  = 2'h1,
		DS_SREF = 2'h3
	} lpr_dstate_t;
endpackage

//--- logic/lpr_link_if.sv
// Command, clock and clock-enable pins between controller and memory
`timescale 1ns/1ps
`include "lpr_consts.svh"
interface lpr_link_if;
	logic                   ck;
	logic                   ckN;
	logic                   cke;
	logic                   csN;
	logic                   rasN;
	logic                   casN;
	logic                   weN;
	logic [`LPR_ADDR_W-1:0] addr;
	logic [1:0]             ba;
	modport ctrl (output ck, ckN, cke, csN, rasN, casN, weN, addr, ba);
	modport dev (input ck, ckN, cke, csN, rasN, casN, weN, addr, ba);
endinterface

//--- logic/lpr_device.sv
// Memory-side bank, refresh, power and mode state, clocked by the link clock
`timescale 1ns/1ps
`include "lpr_consts.svh"
module lpr_device #(
	parameter int unsigned BURST = `LPR_BURST,
	parameter int unsigned TWR   = `LPR_TWR_CYC,
	parameter int unsigned TRP   = `LPR_TRP_CYC,
	parameter int unsigned TRFC  = `LPR_TRFC_CYC
) (
	input  wire logic                   rstn,
	lpr_link_if.dev                     link,
	output logic [`LPR_BANKS-1:0]       bankOpen,
	output logic [`LPR_BANKS-1:0]       bankPrecharging,
	output logic [`LPR_ADDR_W-1:0]      refreshRow,
	output logic                        refreshBusy,
	output logic                        powerDown,
	output logic                        selfRefresh,
	output logic [`LPR_ADDR_W-1:0]      modeReg,
	output logic [`LPR_ADDR_W-1:0]      extModeReg,
	output logic                        modeValid
);
	localparam logic [7:0] AUTO_PRE_LEN = 8'(BURST / 2 + TWR + TRP);

	lpr_pkg::lpr_dstate_t   state, next_state;
	logic                   ckePrev;
	logic [3:0]             cmd;
	logic                   live;
	logic                   allIdle;
	logic [7:0]             refCnt, next_refCnt;
	logic [`LPR_ADDR_W-1:0] next_refreshRow, next_modeReg, next_extModeReg;
	logic                   modeSet, next_modeSet, extSet, next_extSet;

	assign cmd = {link.csN, link.rasN, link.casN, link.weN};
	// Commands count only while awake and CKE held high
	assign live = (state == lpr_pkg::DS_NORM) && ckePrev && link.cke; // [RULE13]
	assign allIdle = (bankOpen == '0) && (bankPrecharging == '0) && (refCnt == 8'h00);

	genvar b;
	generate
		for (b = 0; b < `LPR_BANKS; b++)
		begin : gBank
			logic [7:0] precCnt, next_precCnt;
			logic       next_open;
			logic       hit;
			assign hit = link.ba == 2'(b);
			always_comb
			begin
				next_precCnt = (precCnt != 8'h00) ? precCnt - 8'h01 : precCnt;
				next_open = bankOpen[b];
				// Internal precharge begins once write recovery is over
				if (precCnt == 8'(TRP + 1))
					next_open = 1'b0; // [RULE2]
				if (live)
				begin
					if (cmd == lpr_pkg::CMD_ACT && hit)
						next_open = 1'b1;
					else if (cmd == lpr_pkg::CMD_PRE
						&& (hit || link.addr[`LPR_AUTO_PRECHARGE_FLAG]))
					begin
						next_open = 1'b0;
						next_precCnt = 8'h00;
					end
					else if (cmd == lpr_pkg::CMD_WR && hit
						&& link.addr[`LPR_AUTO_PRECHARGE_FLAG])
						next_precCnt = AUTO_PRE_LEN; // [RULE1]
					else if (cmd == lpr_pkg::CMD_REF)
						next_open = 1'b0; // [RULE6]
				end
			end
			always_ff @(posedge link.ck or negedge rstn)
			begin
				if (!rstn)
				begin
					precCnt <= 8'h00;
					bankOpen[b] <= 1'b0;
					bankPrecharging[b] <= 1'b0;
				end
				else
				begin
					precCnt <= next_precCnt;
					bankOpen[b] <= next_open;
					bankPrecharging[b] <= (next_precCnt != 8'h00) && (next_precCnt <= 8'(TRP));
				end
			end
		end
	endgenerate

	always_comb
	begin
		next_state = state;
		next_refCnt = (refCnt != 8'h00) ? refCnt - 8'h01 : refCnt;
		next_refreshRow = refreshRow;
		next_modeReg = modeReg;
		next_extModeReg = extModeReg;
		next_modeSet = modeSet;
		next_extSet = extSet;
		case (state)
			lpr_pkg::DS_NORM:
			begin
				if (ckePrev && !link.cke)
					next_state = (cmd == lpr_pkg::CMD_REF) ? lpr_pkg::DS_SREF // [RULE8]
						: lpr_pkg::DS_PDN; // [RULE13]
				// Row comes from the internal counter, address pins ignored
				if (live && cmd == lpr_pkg::CMD_REF) // [RULE4]
				begin
					next_refreshRow = refreshRow + `LPR_ADDR_W'(1); // [RULE6]
					next_refCnt = 8'(TRFC);
				end
				// Mode writes accepted only with every bank idle
				if (live && cmd == lpr_pkg::CMD_MRS && allIdle) // [RULE22]
				begin
					if (link.ba == `LPR_BA_MODE)
					begin
						next_modeReg = link.addr;
						next_modeSet = 1'b1;
					end
					else if (link.ba == `LPR_BA_EXT)
					begin
						next_extModeReg = link.addr;
						next_extSet = 1'b1;
					end
				end
			end
			lpr_pkg::DS_PDN, lpr_pkg::DS_SREF:
			begin
				if (link.cke)
					next_state = lpr_pkg::DS_NORM; // [RULE13]
			end
			default:
				next_state = lpr_pkg::DS_NORM;
		endcase
	end

	always_ff @(posedge link.ck or negedge rstn)
	begin
		if (!rstn)
		begin
			state <= lpr_pkg::DS_NORM;
			ckePrev <= 1'b0;
			refCnt <= 8'h00;
			refreshRow <= '0;
			modeReg <= '0;
			extModeReg <= '0;
			modeSet <= 1'b0;
			extSet <= 1'b0;
			refreshBusy <= 1'b0;
			powerDown <= 1'b0;
			selfRefresh <= 1'b0;
			modeValid <= 1'b0;
		end
		else
		begin
			state <= next_state;
			ckePrev <= link.cke;
			refCnt <= next_refCnt;
			refreshRow <= next_refreshRow;
			modeReg <= next_modeReg;
			extModeReg <= next_extModeReg;
			modeSet <= next_modeSet;
			extSet <= next_extSet;
			refreshBusy <= next_refCnt != 8'h00;
			powerDown <= next_state == lpr_pkg::DS_PDN;
			selfRefresh <= next_state == lpr_pkg::DS_SREF;
			modeValid <= next_modeSet && next_extSet;
		end
	end
endmodule

//--- logic/lpr_controller.sv
// Controller end: link clock divider, init sequence, refresh and power states
`timescale 1ns/1ps
`include "lpr_consts.svh"
module lpr_controller #(
	parameter int unsigned INIT_CYC = `LPR_TINIT_CYC,
	parameter int unsigned TRP      = `LPR_TRP_CYC,
	parameter int unsigned TRFC     = `LPR_TRFC_CYC,
	parameter int unsigned TWR      = `LPR_TWR_CYC,
	parameter int unsigned TRCD     = `LPR_TRCD_CYC,
	parameter int unsigned TMRD     = `LPR_TMRD_CYC,
	parameter int unsigned TCKE     = `LPR_TCKE_CYC,
	parameter int unsigned TPDEX    = `LPR_TPDEX_CYC,
	parameter int unsigned PD_MAX   = `LPR_PD_MAX_CYC,
	parameter int unsigned BURST    = `LPR_BURST
) (
	input  wire logic                   clk,
	input  wire logic                   rstn,
	lpr_link_if.ctrl                    link,
	input  wire logic                   cmdValid,
	input  wire lpr_pkg::lpr_op_t       cmdOp,
	input  wire logic                   cmdAutoPrechargeFlag,
	input  wire logic [1:0]             cmdBank,
	input  wire logic [`LPR_ADDR_W-1:0] cmdAddr,
	output logic                        cmdReady,
	input  wire logic                   sleepReq,
	input  wire logic                   selfRefReq,
	input  wire logic                   clkStopReq,
	output logic                        initDone,
	output logic                        powerDown,
	output logic                        selfRefresh,
	output logic                        clockStopped
);
	lpr_pkg::lpr_cstate_t   state, next_state;
	lpr_pkg::lpr_cmd_t      cmd, next_cmd;
	logic                   ck, next_ck;
	logic                   cke, next_cke;
	logic [`LPR_ADDR_W-1:0] addr, next_addr;
	logic [1:0]             ba, next_ba;
	logic [15:0]            waitCnt, next_waitCnt;
	logic [15:0]            dwell, next_dwell;
	logic [1:0]             refs, next_refs;
	logic [3:0]             openMask, next_openMask;
	logic                   adv;
	logic                   legal;
	logic                   bankIsOpen;

	// Pins change on the falling half so the memory samples them mid-cycle
	assign adv = (state == lpr_pkg::CS_STOP) ? 1'b1 : ck;
	assign bankIsOpen = openMask[cmdBank];
	always_comb
	begin
		case (cmdOp)
			lpr_pkg::OP_ACT:   legal = !bankIsOpen;
			lpr_pkg::OP_WRITE: legal = bankIsOpen;
			lpr_pkg::OP_PRE:   legal = 1'b1;
			lpr_pkg::OP_REF:   legal = openMask == 4'h0; // [RULE5]
			default:           legal = 1'b0;
		endcase
	end
	// Clock stop, and power requests once all banks are closed, take priority over user commands
	assign cmdReady = adv && state == lpr_pkg::CS_IDLE && waitCnt == 16'h0000 && legal
		&& !clkStopReq && !(openMask == 4'h0 && (selfRefReq || sleepReq));

	always_comb
	begin
		next_state = state;
		next_cmd = cmd;
		next_cke = cke;
		next_addr = addr;
		next_ba = ba;
		next_waitCnt = waitCnt;
		next_dwell = dwell;
		next_refs = refs;
		next_openMask = openMask;
		// Held low, complement high, while stopped
		next_ck = (state == lpr_pkg::CS_STOP) ? 1'b0 : !ck; // [RULE18]
		if (adv)
		begin
			next_cmd = lpr_pkg::CMD_NOP;
			if (waitCnt != 16'h0000)
				next_waitCnt = waitCnt - 16'h0001;
			if (dwell != 16'hFFFF)
				next_dwell = dwell + 16'h0001;
			case (state)
				lpr_pkg::CS_INIT:
				begin
					// CKE high and NOPs through the power-up wait
					next_cke = 1'b1; // [RULE20]
					if (waitCnt == 16'h0000)
					begin
						next_cmd = lpr_pkg::CMD_PRE; // [RULE21]
						next_addr = `LPR_ADDR_W'(1) << `LPR_AUTO_PRECHARGE_FLAG;
						next_waitCnt = 16'(TRP);
						next_state = lpr_pkg::CS_PALL;
					end
				end
				lpr_pkg::CS_PALL:
				begin
					if (waitCnt == 16'h0000)
					begin
						next_cmd = lpr_pkg::CMD_REF; // [RULE21]
						next_waitCnt = 16'(TRFC);
						next_refs = 2'h1;
						next_state = lpr_pkg::CS_REFI;
					end
				end
				lpr_pkg::CS_REFI:
				begin
					if (waitCnt == 16'h0000 && refs < `LPR_INIT_REFS)
					begin
						next_cmd = lpr_pkg::CMD_REF; // [RULE7]
						next_waitCnt = 16'(TRFC);
						next_refs = refs + 2'h1;
					end
					else if (waitCnt == 16'h0000)
					begin
						next_cmd = lpr_pkg::CMD_MRS; // [RULE22]
						next_ba = `LPR_BA_MODE;
						next_addr = `LPR_MODE_VAL;
						next_waitCnt = 16'(TMRD);
						next_state = lpr_pkg::CS_MRS;
					end
				end
				lpr_pkg::CS_MRS:
				begin
					if (waitCnt == 16'h0000)
					begin
						next_cmd = lpr_pkg::CMD_MRS; // [RULE21]
						next_ba = `LPR_BA_EXT;
						next_addr = `LPR_EXT_VAL;
						next_waitCnt = 16'(TMRD);
						next_state = lpr_pkg::CS_EMRS;
					end
				end
				lpr_pkg::CS_EMRS:
				begin
					if (waitCnt == 16'h0000)
						next_state = lpr_pkg::CS_IDLE;
				end
				lpr_pkg::CS_IDLE:
				begin
					if (waitCnt != 16'h0000)
						next_state = state;
					else if (clkStopReq)
						next_state = lpr_pkg::CS_STOP; // [RULE17]
					else if (openMask == 4'h0 && selfRefReq)
					begin
						next_cmd = lpr_pkg::CMD_REF; // [RULE8] [RULE12]
						next_cke = 1'b0;
						next_dwell = 16'h0000;
						next_state = lpr_pkg::CS_SREF;
					end
					else if (openMask == 4'h0 && sleepReq)
					begin
						next_cke = 1'b0; // [RULE14]
						next_dwell = 16'h0000;
						next_state = lpr_pkg::CS_PDN;
					end
					else if (cmdValid && cmdReady)
					begin
						next_ba = cmdBank;
						next_addr = cmdAddr;
						case (cmdOp)
							lpr_pkg::OP_ACT:
							begin
								next_cmd = lpr_pkg::CMD_ACT;
								next_openMask[cmdBank] = 1'b1;
								next_waitCnt = 16'(TRCD);
							end
							lpr_pkg::OP_WRITE:
							begin
								next_cmd = lpr_pkg::CMD_WR;
								next_addr[`LPR_AUTO_PRECHARGE_FLAG] = cmdAutoPrechargeFlag;
								if (cmdAutoPrechargeFlag)
								begin
									// Hold off all commands until the auto precharge ends
									next_openMask[cmdBank] = 1'b0;
									next_waitCnt = 16'(BURST / 2 + TWR + TRP); // [RULE3]
								end
								else
									next_waitCnt = 16'(BURST / 2);
							end
							lpr_pkg::OP_PRE:
							begin
								next_cmd = lpr_pkg::CMD_PRE;
								if (cmdAddr[`LPR_AUTO_PRECHARGE_FLAG])
									next_openMask = 4'h0;
								else
									next_openMask[cmdBank] = 1'b0;
								next_waitCnt = 16'(TRP);
							end
							lpr_pkg::OP_REF:
							begin
								next_cmd = lpr_pkg::CMD_REF; // [RULE4]
								next_waitCnt = 16'(TRFC); // [RULE7]
							end
							default:
								next_cmd = lpr_pkg::CMD_NOP;
						endcase
					end
				end
				lpr_pkg::CS_PDN:
				begin
					// Leave at least tCKE in, forced out before the refresh period
					if ((!sleepReq && dwell >= 16'(TCKE)) // [RULE16]
						|| dwell >= 16'(PD_MAX)) // [RULE15]
					begin
						next_cke = 1'b1;
						next_waitCnt = 16'(TPDEX); // [RULE14]
						next_state = lpr_pkg::CS_IDLE;
					end
				end
				lpr_pkg::CS_SREF:
				begin
					// CKE driven low, clock kept running with NOPs
					if (!selfRefReq && dwell >= 16'(TRFC)) // [RULE9] [RULE10] [RULE12]
					begin
						next_cke = 1'b1; // [RULE11]
						next_waitCnt = 16'(TRFC);
						next_state = lpr_pkg::CS_IDLE;
					end
				end
				lpr_pkg::CS_STOP:
				begin
					if (!clkStopReq)
					begin
						next_waitCnt = 16'(`LPR_RESTART_NOP_CYC); // [RULE19]
						next_state = lpr_pkg::CS_IDLE;
					end
				end
				default:
					next_state = lpr_pkg::CS_INIT;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state <= lpr_pkg::CS_INIT;
			cmd <= lpr_pkg::CMD_NOP;
			ck <= 1'b0;
			cke <= 1'b1;
			addr <= '0;
			ba <= 2'h0;
			waitCnt <= 16'(INIT_CYC);
			dwell <= 16'h0000;
			refs <= 2'h0;
			openMask <= 4'h0;
		end
		else
		begin
			state <= next_state;
			cmd <= next_cmd;
			ck <= next_ck;
			cke <= next_cke;
			addr <= next_addr;
			ba <= next_ba;
			waitCnt <= next_waitCnt;
			dwell <= next_dwell;
			refs <= next_refs;
			openMask <= next_openMask;
		end
	end

	assign link.ck = ck;
	assign link.ckN = !ck;
	assign link.cke = cke;
	assign {link.csN, link.rasN, link.casN, link.weN} = cmd;
	assign link.addr = addr;
	assign link.ba = ba;
	assign initDone = state == lpr_pkg::CS_IDLE || state == lpr_pkg::CS_PDN
		|| state == lpr_pkg::CS_SREF || state == lpr_pkg::CS_STOP;
	assign powerDown = state == lpr_pkg::CS_PDN;
	assign selfRefresh = state == lpr_pkg::CS_SREF;
	assign clockStopped = state == lpr_pkg::CS_STOP;
endmodule

//--- sim/lpr_link_asserts.sv
// Protocol checks on the controller-to-memory link
`timescale 1ns/1ps
module lpr_link_asserts #(
	parameter int unsigned TRP   = 3,
	parameter int unsigned TRFC  = 12,
	parameter int unsigned TCKE  = 2,
	parameter int unsigned TPDEX = 2
) (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic ck,
	input  wire logic ckN,
	input  wire logic cke,
	input  wire logic csN,
	input  wire logic rasN,
	input  wire logic casN,
	input  wire logic weN
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	logic       ckQ;
	logic       taken;
	logic [3:0] cmd;
	logic [7:0] sinceRef;
	logic [7:0] sincePre;
	logic [7:0] lowRun;
	logic [7:0] highRun;
	logic [7:0] ckLow;
	function automatic logic [7:0] inc(input logic [7:0] v);
		return (v == 8'hFF) ? v : v + 8'h01;
	endfunction
	assign cmd   = {csN, rasN, casN, weN};
	// A link edge is the first clk sample that sees ck high
	assign taken = ck && !ckQ;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ckQ      <= 1'b0;
			sinceRef <= 8'hFF;
			sincePre <= 8'hFF;
			lowRun   <= 8'h00;
			highRun  <= 8'h00;
			ckLow    <= 8'h00;
		end
		else
		begin
			ckQ      <= ck;
			sinceRef <= (taken && cmd == 4'h1) ? 8'h00 : inc(sinceRef);
			sincePre <= (taken && cmd == 4'h2) ? 8'h00 : inc(sincePre);
			lowRun   <= cke ? 8'h00 : inc(lowRun);
			highRun  <= cke ? inc(highRun) : 8'h00;
			ckLow    <= ck ? 8'h00 : inc(ckLow);
		end
	end
	clk_pair_a: assert property (ckN == !ck)
		else $error("ck and ckN not complementary");
	stop_cke_a: assert property (!ck && ckLow != 8'h00 |-> cke)
		else $error("clock held low with cke low");
	ref_gap_a: assert property (taken && cke && (cmd == 4'h3 || cmd == 4'h1) |-> sinceRef >= 2 * TRFC - 1)
		else $error("command too soon after refresh");
	ref_idle_a: assert property (taken && cke && cmd == 4'h1 |-> sincePre >= 2 * TRP - 1)
		else $error("refresh too soon after precharge");
	sref_hold_a: assert property (taken && !cke && cmd == 4'h1 |=> !cke [*8])
		else $error("cke rose early in self refresh");
	sref_min_a: assert property ($rose(cke) && sinceRef < lowRun |-> lowRun >= 2 * TRFC - 1)
		else $error("self refresh shorter than refresh cycle");
	pd_min_a: assert property ($rose(cke) |-> lowRun >= 2 * TCKE - 1)
		else $error("power down shorter than minimum");
	exit_nop_a: assert property ($rose(cke) |-> (csN || cmd == 4'h7) && ckLow < 8'h02)
		else $error("cke rose without nop and running clock");
	pdex_act_a: assert property (taken && cke && cmd == 4'h3 |-> highRun >= 2 * TPDEX)
		else $error("activate too soon after cke rise");
	restart_nop_a: assert property (taken && ckLow > 8'h01 |-> csN || cmd == 4'h7)
		else $error("no nop after clock restart");
endmodule

//--- sim/testbench.sv
// Paired controller and memory, plus a memory driven directly on a second link
`timescale 1ns/1ps
`include "lpr_consts.svh"
module testbench;
	logic                   clk, rstn, cmdValid, cmdAutoPrechargeFlag, cmdReady, sleepReq;
	logic                   selfRefReq;
	logic                   clkStopReq, initDone, cPd, cSr, cStop, dPd, dSr, dBusy, dValid, mValid;
	lpr_pkg::lpr_op_t       cmdOp;
	logic [1:0]             cmdBank;
	logic [`LPR_ADDR_W-1:0] cmdAddr, dRow, dMode, dExt, mMode, mExt, r0;
	logic [`LPR_BANKS-1:0]  mOpen, dOpen, dPre;
	int                     mismatches, n_checks, k;
	lpr_link_if link ();
	lpr_link_if link2 ();
	lpr_controller #(.INIT_CYC(10), .PD_MAX(20)) u_lpr_controller (.clk(clk), .rstn(rstn),
		.link(link), .cmdValid(cmdValid), .cmdOp(cmdOp),
		.cmdAutoPrechargeFlag(cmdAutoPrechargeFlag), .cmdBank(cmdBank),
		.cmdAddr(cmdAddr), .cmdReady(cmdReady), .sleepReq(sleepReq), .selfRefReq(selfRefReq),
		.clkStopReq(clkStopReq), .initDone(initDone), .powerDown(cPd), .selfRefresh(cSr),
		.clockStopped(cStop));
	lpr_device u_lpr_device (.rstn(rstn), .link(link), .bankOpen(mOpen), .bankPrecharging(),
		.refreshRow(), .refreshBusy(), .powerDown(), .selfRefresh(), .modeReg(mMode),
		.extModeReg(mExt), .modeValid(mValid));
	lpr_device u_lpr_device_b (.rstn(rstn), .link(link2), .bankOpen(dOpen),
		.bankPrecharging(dPre), .refreshRow(dRow), .refreshBusy(dBusy), .powerDown(dPd),
		.selfRefresh(dSr), .modeReg(dMode), .extModeReg(dExt), .modeValid(dValid));
	lpr_link_asserts u_lpr_link_asserts (.clk(clk), .rstn(rstn), .ck(link.ck), .ckN(link.ckN),
		.cke(link.cke), .csN(link.csN), .rasN(link.rasN), .casN(link.casN), .weN(link.weN));
	always #20 clk = ~clk;
	task automatic chk(input string n, input logic [12:0] e, input logic [12:0] g);
		n_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// One command per 64 ns link clock period, pins change while ck is low
	task automatic dcmd(input lpr_pkg::lpr_cmd_t c, input logic [1:0] b, input logic [12:0] a,
		input logic e);
		{link2.csN, link2.rasN, link2.casN, link2.weN} <= c;
		link2.ba   <= b;
		link2.addr <= a;
		link2.cke  <= e;
		#16 link2.ck <= 1'b1;
		link2.ckN  <= 1'b0;
		#32 link2.ck <= 1'b0;
		link2.ckN  <= 1'b1;
		#16;
	endtask
	task automatic nops(input int n, input logic e);
		repeat (n) dcmd(lpr_pkg::CMD_NOP, 2'h0, 13'h0000, e);
	endtask
	task automatic send(input lpr_pkg::lpr_op_t o, input logic a, input logic [1:0] b,
		input logic [12:0] ad);
		int i;
		@(posedge clk);
		cmdValid <= 1'b1;
		cmdOp    <= o;
		cmdAutoPrechargeFlag <= a;
		cmdBank  <= b;
		cmdAddr  <= ad;
		for (i = 0; i < 200; i++)
		begin
			@(posedge clk);
			if (cmdReady === 1'b1)
				break;
		end
		chk("cmdReady", 13'h1, cmdReady);
		cmdValid <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic waitc(ref logic s, input logic v);
		int i;
		for (i = 0; i < 400 && s !== v; i++)
			@(posedge clk);
		chk("level", v, s);
	endtask
	initial
	begin
		#400000;
		mismatches++;
		stop_test;
	end
	initial
	begin
		// Let every process wait first so reset is seen as an edge
		#1;
		{clk, rstn, cmdValid, cmdAutoPrechargeFlag, sleepReq, selfRefReq, clkStopReq} = 7'h00;
		cmdOp   = lpr_pkg::OP_ACT;
		cmdBank = 2'h0;
		cmdAddr = 13'h0000;
		{link2.ck, link2.ckN, link2.cke, link2.csN, link2.rasN, link2.casN, link2.weN} = 7'h3F;
		link2.addr = 13'h0000;
		link2.ba   = 2'h0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		chk("modeValid", 13'h0, dValid);
		// First edge only records CKE as high
		nops(1, 1'b1);
		dcmd(lpr_pkg::CMD_MRS, 2'h0, `LPR_MODE_VAL, 1'b1);
		dcmd(lpr_pkg::CMD_MRS, 2'h2, 13'h0040, 1'b1);
		chk("modeReg", `LPR_MODE_VAL, dMode);
		chk("extModeReg", 13'h0040, dExt);
		chk("modeValid", 13'h1, dValid);
		dcmd(lpr_pkg::CMD_ACT, 2'h1, 13'h0100, 1'b1);
		dcmd(lpr_pkg::CMD_ACT, 2'h2, 13'h0100, 1'b1);
		dcmd(lpr_pkg::CMD_WR, 2'h2, 13'h0000, 1'b1);
		dcmd(lpr_pkg::CMD_WR, 2'h1, 13'h0400, 1'b1);
		nops(3, 1'b1);
		chk("bankOpen", 13'h6, dOpen);
		chk("bankPrecharging", 13'h0, dPre);
		nops(1, 1'b1);
		chk("bankOpen", 13'h4, dOpen);
		chk("bankPrecharging", 13'h2, dPre);
		nops(3, 1'b1);
		chk("bankPrecharging", 13'h0, dPre);
		dcmd(lpr_pkg::CMD_PRE, 2'h0, 13'h0400, 1'b1);
		nops(3, 1'b1);
		r0 = dRow;
		for (k = 1; k <= 2; k++)
		begin
			dcmd(lpr_pkg::CMD_REF, 2'h3, 13'h1ABC, 1'b1);
			chk("refreshBusy", 13'h1, dBusy);
			chk("refreshRow", r0 + k[12:0], dRow);
			nops(`LPR_TRFC_CYC, 1'b1);
			chk("refreshBusy", 13'h0, dBusy);
			chk("bankOpen", 13'h0, dOpen);
		end
		nops(1, 1'b0);
		chk("powerDown", 13'h1, dPd);
		dcmd(lpr_pkg::CMD_ACT, 2'h3, 13'h0000, 1'b0);
		chk("bankOpen", 13'h0, dOpen);
		nops(1, 1'b1);
		chk("powerDown", 13'h0, dPd);
		dcmd(lpr_pkg::CMD_REF, 2'h0, 13'h0000, 1'b0);
		chk("selfRefresh", 13'h1, dSr);
		nops(`LPR_TRFC_CYC, 1'b0);
		nops(2, 1'b1);
		chk("selfRefresh", 13'h0, dSr);
		waitc(initDone, 1'b1);
		chk("modeReg", `LPR_MODE_VAL, mMode);
		chk("extModeReg", `LPR_EXT_VAL, mExt);
		chk("modeValid", 13'h1, mValid);
		send(lpr_pkg::OP_ACT, 1'b0, 2'h0, 13'h0010);
		chk("bankOpen", 13'h1, mOpen);
		send(lpr_pkg::OP_WRITE, 1'b1, 2'h0, 13'h0020);
		send(lpr_pkg::OP_REF, 1'b0, 2'h0, 13'h0000);
		chk("bankOpen", 13'h0, mOpen);
		sleepReq <= 1'b1;
		waitc(cPd, 1'b1);
		chk("cke", 13'h0, link.cke);
		sleepReq <= 1'b0;
		waitc(cPd, 1'b0);
		// Held request: only the power-down limit brings the link back
		sleepReq <= 1'b1;
		waitc(cPd, 1'b1);
		waitc(cPd, 1'b0);
		sleepReq <= 1'b0;
		send(lpr_pkg::OP_ACT, 1'b0, 2'h1, 13'h0030);
		chk("bankOpen", 13'h2, mOpen);
		send(lpr_pkg::OP_PRE, 1'b0, 2'h0, 13'h0400);
		selfRefReq <= 1'b1;
		waitc(cSr, 1'b1);
		chk("cke", 13'h0, link.cke);
		selfRefReq <= 1'b0;
		waitc(cSr, 1'b0);
		clkStopReq <= 1'b1;
		waitc(cStop, 1'b1);
		chk("ck", 13'h0, link.ck);
		chk("ckN", 13'h1, link.ckN);
		clkStopReq <= 1'b0;
		waitc(cStop, 1'b0);
		send(lpr_pkg::OP_ACT, 1'b0, 2'h2, 13'h0000);
		chk("bankOpen", 13'h4, mOpen);
		stop_test;
	end
endmodule
